// file: core/sbm_cfg.svh
// Constants for the serial Booth multiplier and its source
`ifndef SBM_CFG_SVH
`define SBM_CFG_SVH
`define SBM_X_WIDTH      8
`define SBM_Y_WIDTH      8
`define SBM_RUN_PERIODS  18
`define SBM_SIGN_REPEAT  8
`endif

// file: core/sbm_pkg.sv
// Types shared by the serial Booth multiplier ends
package sbm_pkg;
  typedef enum logic [1:0] {
    SBM_IDLE,
    SBM_CLEAR,
    SBM_RUN
  } sbm_state_t;
endpackage

// file: core/sbm_link_if.sv
// Link between the multiplier source and the multiplier device
`timescale 1ns/10ps
interface sbm_link_if #(parameter int XW = 8);
  logic [XW-1:0] multiplicandIn;
  logic          multiplierBit;
  logic          loadClear_n;
  logic          expansionIn;
  logic          topSelect;
  logic          productSerialOut;
  modport dev (
    input  multiplicandIn,
    input  multiplierBit,
    input  loadClear_n,
    input  expansionIn,
    input  topSelect,
    output productSerialOut
  );
  modport src (
    output multiplicandIn,
    output multiplierBit,
    output loadClear_n,
    output expansionIn,
    output topSelect,
    input  productSerialOut
  );
endinterface

// file: core/sbm_multiplier.sv
// Serial/parallel Booth multiplier device, carry-save cells
// ==========================================================
// What this block does
// - Capture and hold eight-bit signed multiplicand
// - Source sends multiplier bits, LSB first
// - Product leaves serially, LSB first
// - Booth recoding gives signed product directly
// - Latches open while load low, hold after
// - Load low clears previous bit, carries, sums
// - Load low forces product output low
// - Pair 0,1 adds; equal pair only shifts
// - Pair 1,0 subtracts multiplicand then shifts
// - Other state changes on rising clock edge
// - Load/clear is sampled on the rising clock edge
// - Top device: select low, expansion low
// - Lower device: select high, expansion chained
// - Carry-save cells; top cell uses expansion
// - Load low one bit time after edge
// - First product bit out after first edge
// - Each later bit from one cell upstream
// - Source repeats sign bit nine more times in a run
// - Eight by eight run takes 18 periods
// - Full-width multiplicand; no upper inputs tied to sign
`timescale 1ns/10ps
`include "sbm_cfg.svh"
module sbm_multiplier
  import sbm_pkg::*;
#(
  parameter int XW = `SBM_X_WIDTH
) (
  input wire logic clk,
  input wire logic reset_n,
  sbm_link_if.dev  link
);
  // ==========================================================
  // Multiplicand latch
  // Load/clear is sampled with the clock: in a synchronous core
  // the transparent latch becomes a register loaded while low.
  logic [XW-1:0] mcand_q;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mcand_q <= '0;
    end else if (!link.loadClear_n) begin
      mcand_q <= link.multiplicandIn;
    end
  end

  // ==========================================================
  // Booth recoding
  // Each edge pairs the bit on the line with the bit seen one edge
  // earlier. The previous bit starts at zero after a clear, so a
  // multiplier whose low bit is one opens with a subtraction.
  logic clearNow;
  assign clearNow = !link.loadClear_n;

  function automatic logic booth_is_add(
    input logic cur,
    input logic prev
  );
    return !cur && prev;
  endfunction

  function automatic logic booth_is_sub(
    input logic cur,
    input logic prev
  );
    return cur && !prev;
  endfunction

  logic prevBit_q;
  logic doAdd;
  logic doSub;

  assign doAdd = booth_is_add(link.multiplierBit, prevBit_q);
  assign doSub = booth_is_sub(link.multiplierBit, prevBit_q);

  // Cleared with the sums so that no stale pair survives a new run
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prevBit_q <= 1'b0;
    end else if (clearNow) begin
      prevBit_q <= 1'b0;
    end else begin
      prevBit_q <= link.multiplierBit;
    end
  end

  // ==========================================================
  // Operand widening
  // The array is twice the multiplicand width. Sign bits that are
  // wrong at the very top of a carry-save word can only disturb
  // weights above the last product bit, so the top cell needs no
  // exact sign recovery. A longer product needs a wider array.
  // Negating the most negative multiplicand also fits at this width.
  localparam int AW = 2 * XW;

  function automatic logic [AW-1:0] sign_extend(
    input logic [XW-1:0] value
  );
    return {{(AW - XW){value[XW-1]}}, value};
  endfunction

  function automatic logic [AW-1:0] negate(
    input logic [AW-1:0] value
  );
    return ~value + AW'(1);
  endfunction

  // The negated multiplicand is formed once while the latch is open,
  // which keeps a full-width adder off the per-edge path.
  logic [AW-1:0] mcandNeg_q;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mcandNeg_q <= '0;
    end else if (clearNow) begin
      mcandNeg_q <= negate(sign_extend(link.multiplicandIn));
    end
  end

  logic [AW-1:0] mcandPos;
  assign mcandPos = sign_extend(mcand_q);

  // A bare shift adds zero
  logic [AW-1:0] addend;
  always_comb begin
    if (doSub) begin
      addend = mcandNeg_q;
    end else if (doAdd) begin
      addend = mcandPos;
    end else begin
      addend = '0;
    end
  end

  // ==========================================================
  // Carry-save array; cell AW-1 is the top cell
  function automatic logic fa_sum(
    input logic a,
    input logic b,
    input logic c
  );
    return a ^ b ^ c;
  endfunction

  function automatic logic fa_carry(
    input logic a,
    input logic b,
    input logic c
  );
    return (a & b) | (a & c) | (b & c);
  endfunction

  logic [AW-1:0] sum_q;
  logic [AW-1:0] carry_q;
  logic [AW-1:0] upper;
  logic [AW-1:0] sumD;
  logic [AW-1:0] carryD;
  logic          topInput;

  // ==========================================================
  // Cascade top input
  // A lower device takes the next device's output as its top addend;
  // the top device feeds zero there whatever the expansion pin shows.
  // Chained devices only meet the low product bits at this width.
  assign topInput = link.topSelect ? link.expansionIn : 1'b0;
  assign upper    = {topInput, sum_q[AW-1:1]};

  always_comb begin
    sumD   = '0;
    carryD = '0;
    for (int i = 0; i < AW; i++) begin
      sumD[i]   = fa_sum(addend[i], upper[i], carry_q[i]);
      carryD[i] = fa_carry(addend[i], upper[i], carry_q[i]);
    end
  end

  // ==========================================================
  // Sum and carry registers
  // Sums shift one cell down each edge; carries stay in their cell
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sum_q <= '0;
    end else if (clearNow) begin
      sum_q <= '0;
    end else begin
      sum_q <= sumD;
    end
  end

  // A carry has twice its cell's weight, which the shift absorbs
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      carry_q <= '0;
    end else if (clearNow) begin
      carry_q <= '0;
    end else begin
      carry_q <= carryD;
    end
  end

  // ==========================================================
  // Serial product output
  // No extra flop: the bit stands right after the edge that forms it
  assign link.productSerialOut = sum_q[0];
endmodule

// file: core/sbm_source.sv
// Multiplier word source that drives the serial multiplier link
`timescale 1ns/10ps
`include "sbm_cfg.svh"
module sbm_source
  import sbm_pkg::*;
#(
  parameter int XW = `SBM_X_WIDTH,
  parameter int YW = `SBM_Y_WIDTH
) (
  input  wire logic          clk,
  input  wire logic          reset_n,
  input  wire logic          start,
  input  wire logic [XW-1:0] multiplicand,
  input  wire logic [YW-1:0] multiplier,
  input  wire logic          cascadeLow,
  input  wire logic          cascadeIn,
  output logic               busy,
  output logic               productValid,
  output logic [2*YW-1:0]    product,
  sbm_link_if.src            link
);
  localparam int RUN = `SBM_RUN_PERIODS;
  sbm_state_t    state_q;
  logic [4:0]    cnt_q;
  logic [YW-1:0] ybuf_q;
  logic [XW-1:0] xbuf_q;
  logic [2*YW-1:0] prod_q;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= SBM_IDLE;
      cnt_q   <= '0;
      ybuf_q  <= '0;
      xbuf_q  <= '0;
    end else begin
      case (state_q)
        SBM_IDLE: begin
          if (start) begin
            state_q <= SBM_CLEAR;
            ybuf_q  <= multiplier;
            xbuf_q  <= multiplicand;
            cnt_q   <= '0;
          end
        end
        SBM_CLEAR: begin
          state_q <= SBM_RUN;
          cnt_q   <= 5'h01;
        end
        SBM_RUN: begin
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == 5'(RUN - 1)) begin
            state_q <= SBM_IDLE;
          end
        end
        default: state_q <= SBM_IDLE;
      endcase
    end
  end

  // Bit time k (1..) presents y[k-1]; sign repeats past the MSB
  logic [4:0] idx;
  assign idx = cnt_q - 5'h01;
  always_comb begin
    if (state_q == SBM_RUN && idx < 5'(YW)) begin
      link.multiplierBit = ybuf_q[idx[2:0]];
    end else begin
      link.multiplierBit = ybuf_q[YW-1];
    end
  end

  assign link.loadClear_n    = (state_q != SBM_CLEAR);
  // Full-width multiplicand: no upper inputs are left to tie to sign
  assign link.multiplicandIn = xbuf_q;
  assign link.topSelect      = cascadeLow;
  assign link.expansionIn    = cascadeLow ? cascadeIn : 1'b0;

  // Product bit k appears after edge that opens bit time k+2
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prod_q       <= '0;
      productValid <= 1'b0;
    end else begin
      productValid <= 1'b0;
      if (state_q == SBM_RUN && cnt_q >= 5'h02) begin
        prod_q <= {link.productSerialOut, prod_q[2*YW-1:1]};
      end
      if (state_q == SBM_RUN && cnt_q == 5'(RUN - 1)) begin
        productValid <= 1'b1;
      end
    end
  end
  assign product = prod_q;
  assign busy    = (state_q != SBM_IDLE);
endmodule

// file: bench/sbm_link_asserts.sv
// Assertions watching the link between source and multiplier
`timescale 1ns/10ps
module sbm_link_asserts (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic [7:0] multiplicandIn,
  input wire logic       multiplierBit,
  input wire logic       loadClear_n,
  input wire logic       expansionIn,
  input wire logic       topSelect,
  input wire logic       productSerialOut
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // Clear framing
  a_clear_pulse: assert property (
    !loadClear_n |=> loadClear_n) else $error("clear held too long");
  a_run_span: assert property (
    $fell(loadClear_n) |=> loadClear_n[*8] ##1 loadClear_n[*8]
    ##1 loadClear_n) else $error("run shorter than 18 periods");
  a_out_low: assert property (
    !loadClear_n |=> !productSerialOut) else $error("output not cleared");
  // ==========================================================
  // Serial arithmetic
  a_first_bit: assert property (
    $fell(loadClear_n) |-> ##2 productSerialOut ==
    ($past(multiplicandIn[0], 2) & $past(multiplierBit)))
    else $error("first product bit wrong");
  a_zero_mcand: assert property (
    $fell(loadClear_n) && multiplicandIn == 8'h00 |->
    ##2 !productSerialOut[*8] ##1 !productSerialOut[*8])
    else $error("zero multiplicand gave nonzero bit");
  a_sign_repeat: assert property (
    $fell(loadClear_n) |-> ##9 $stable(multiplierBit)[*8])
    else $error("sign bit not repeated");
  // ==========================================================
  // Chain configuration
  a_top_quiet: assert property (
    topSelect || !expansionIn) else $error("top device expansion high");
  a_topsel_const: assert property (
    $fell(loadClear_n) |=> $stable(topSelect)[*8])
    else $error("select changed in run");
  c_run: cover property ($fell(loadClear_n));
  c_zero: cover property ($fell(loadClear_n) && multiplicandIn == 8'h00);
  c_min: cover property ($fell(loadClear_n) && multiplicandIn == 8'h80);
endmodule

// file: bench/tb_top.sv
// Self-checking bench for the serial Booth multiplier pair
`timescale 1ns/10ps
module tb_top;
  logic        clk, reset_n, start, busy, productValid;
  logic [7:0]  multiplicand, multiplier;
  logic [15:0] product;
  int          mismatches = 0;
  int          cmp_count = 0;
  logic [7:0]  xs[5] = '{8'h00, 8'h80, 8'h80, 8'hff, 8'h7f};
  logic [7:0]  ys[5] = '{8'h05, 8'h80, 8'h7f, 8'h01, 8'h81};
  sbm_link_if #(.XW(8)) link ();
  sbm_source sbm_source_inst (.clk(clk), .reset_n(reset_n),
    .start(start), .multiplicand(multiplicand), .multiplier(multiplier),
    .cascadeLow(1'b0), .cascadeIn(1'b0), .busy(busy),
    .productValid(productValid), .product(product), .link(link));
  sbm_multiplier sbm_multiplier_inst (.clk(clk), .reset_n(reset_n),
    .link(link));
  sbm_link_asserts sbm_link_asserts_inst (.clk(clk), .reset_n(reset_n),
    .multiplicandIn(link.multiplicandIn),
    .multiplierBit(link.multiplierBit), .loadClear_n(link.loadClear_n),
    .expansionIn(link.expansionIn), .topSelect(link.topSelect),
    .productSerialOut(link.productSerialOut));
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, s);
    end
  endtask
  task end_sim;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Product is read the cycle after the valid pulse
  task run(input logic [7:0] a, input logic [7:0] b);
    int n;
    int e;
    e = $signed(a) * $signed(b);
    @(posedge clk) #1;
    multiplicand = a;
    multiplier = b;
    start = 1;
    @(posedge clk) #1;
    start = 0;
    chk("busy", 16'(busy), 16'h0001);
    n = 0;
    while (productValid !== 1'b1 && n < 40) begin
      @(posedge clk) #1;
      n++;
    end
    if (n >= 40) begin
      mismatches++;
    end
    chk("run cycles", 16'(n), 16'h0012);
    chk("busy", 16'(busy), 16'h0000);
    @(posedge clk) #1;
    chk("product", product, 16'(e));
  endtask
  initial begin
    repeat (2500) @(posedge clk);
    mismatches++;
    end_sim();
  end
  initial begin
    reset_n = 0;
    start = 0;
    multiplicand = 8'h00;
    multiplier = 8'h00;
    void'($urandom(32'hb21a));
    repeat (12) @(posedge clk);
    #1 reset_n = 1;
    foreach (xs[i]) run(xs[i], ys[i]);
    $display("corner test done");
    for (int i = 0; i < 40; i++) run(8'($urandom), 8'($urandom));
    $display("random test done");
    end_sim();
  end
endmodule
